// file: dv/tpq_host_model.sv
// i2c master model standing for the host processor
module tpq_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // sda moves only while scl low, scl phases of four clocks
    task automatic put_bit(input logic b, output logic r);
        tick(2);
        o_sda_drv = b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        r = i_sda;
        tick(2);
        o_scl = 1'b0;
    endtask

    task automatic start_cond();
        tick(2);
        o_sda_drv = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_drv = 1'b0;
        tick(4);
        o_scl = 1'b0;
    endtask

    task automatic stop_cond();
        tick(2);
        o_sda_drv = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_drv = 1'b1;
        tick(4);
    endtask

    // msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(ack_in, ack_out);
    endtask

    task automatic send_pkt(input logic [6:0] addr, input logic [31:0] p, output logic [4:0] acks);
        logic [7:0] rx;
        start_cond();
        xfer({addr, 1'b0}, 1'b1, rx, acks[4]);
        for (int k = 0; k < 4; k++) begin
            xfer(p[31-8*k -: 8], 1'b1, rx, acks[3-k]);
        end
        stop_cond();
    endtask

    // master acks bytes one to three and refuses the fourth
    task automatic fetch_pkt(output logic [31:0] p, output logic addr_ack);
        logic ign;
        start_cond();
        xfer({tpq_pkg::TPQ_I2C_ADDR, 1'b1}, 1'b1, p[31:24], addr_ack);
        p = 32'hffff_ffff;
        if (addr_ack === 1'b0) begin
            for (int k = 0; k < 4; k++) begin
                xfer(8'hff, (k == 3), p[31-8*k -: 8], ign);
            end
        end
        stop_cond();
    endtask
endmodule

// file: dv/tpq_packet_monitor.sv
// concurrent checks on the ports of the packet handler
module tpq_packet_monitor (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  wire logic                   i_scl,
    input  wire logic                   i_sda,
    input  wire logic                   o_sda_out,
    input  wire logic                   o_sda_oe,
    input  wire tpq_pkg::tpq_power_type o_power_state,
    input  wire logic [3:0]             o_report_rate,
    input  wire logic                   o_resp_pending
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_sda_open_drain: assert property (o_sda_out == 1'b0) else $error("sda data not low");
    a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("sda taken while scl high");
    a_oe_hold_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe)) else $error("sda moved in high");
    a_state_legal: assert property (o_power_state != 2'b11) else $error("power state code 11");
    a_rate_reserved: assert property (o_power_state != tpq_pkg::TPQ_PWR_NORMAL |-> o_report_rate == 4'h0)
        else $error("rate not zero outside normal");
    a_rate_normal: assert property ($changed(o_report_rate) |-> o_power_state == tpq_pkg::TPQ_PWR_NORMAL
        || $changed(o_power_state)) else $error("rate moved without normal");
    a_state_scl_low: assert property ($changed(o_power_state) |-> !i_scl) else $error("state moved in scl high");
    a_state_hold: assert property ($changed(o_power_state) |=> $stable(o_power_state) [*8])
        else $error("state moved twice in one packet");
    // the reply is armed while the fourth request byte is being acked
    a_pending_low: assert property ($rose(o_resp_pending) |-> !i_scl && o_sda_oe)
        else $error("reply pending at wrong moment");

    c_deep: cover property ($changed(o_power_state) && o_power_state == tpq_pkg::TPQ_PWR_DEEP);
    c_idle: cover property ($changed(o_power_state) && o_power_state == tpq_pkg::TPQ_PWR_IDLE);
    c_wake: cover property ($past(o_power_state) == tpq_pkg::TPQ_PWR_DEEP && o_power_state == tpq_pkg::TPQ_PWR_NORMAL);
    c_reply: cover property ($fell(o_resp_pending));
endmodule

bind tpq_packet_top tpq_packet_monitor i_mon (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_power_state(o_power_state), .o_report_rate(o_report_rate),
    .o_resp_pending(o_resp_pending)
);

// file: dv/tpq_packet_top_tb_top.sv
// self-checking bench for the packet handler
module tpq_packet_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [3:0] FW_X = 4'h3;  // arbitrary value
    localparam logic [3:0] FW_Y = 4'h6;  // arbitrary value
    localparam logic [7:0] ST_B[10] = '{8'h58, 8'h58, 8'h58, 8'h58, 8'h54, 8'h50, 8'h54, 8'h58, 8'h50, 8'h58};
    localparam logic [7:0] RT_B[10] = '{8'h0f, 8'h07, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h0a};

    logic                   i_clk;
    logic                   i_resetn;
    logic                   scl;
    logic                   host_sda;
    logic                   sda_wire;
    logic                   o_sda_out;
    logic                   o_sda_oe;
    tpq_pkg::tpq_power_type o_power_state;
    logic [3:0]             o_report_rate;
    logic                   o_resp_pending;
    logic [31:0]            rsp;
    logic [4:0]             acks;
    logic                   aack;
    logic [3:0]             exp_rt;
    int                     err_count;
    int                     tests_run;
    int                     cycles;

    // pulled-up wire, low when either party pulls
    assign sda_wire = host_sda & ~o_sda_oe;

    tpq_packet_top #(.FW_MINOR_X(FW_X), .FW_MINOR_Y(FW_Y)) i_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_wire), .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe), .o_power_state(o_power_state), .o_report_rate(o_report_rate),
        .o_resp_pending(o_resp_pending)
    );

    tpq_host_model u_host (.i_clk(i_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_drv(host_sda));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ask for a reply and read all four bytes back
    task automatic query(input logic [7:0] sel, input logic [31:0] exp);
        u_host.send_pkt(tpq_pkg::TPQ_I2C_ADDR, {8'h53, sel, 8'h00, 8'h01}, acks);
        chk("write acks", {3'h0, acks}, 8'h00);
        chk("pending set", {7'h0, o_resp_pending}, 8'h01);
        u_host.fetch_pkt(rsp, aack);
        chk("read addr ack", {7'h0, aack}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            chk("reply byte", rsp[31-8*k -: 8], exp[31-8*k -: 8]);
        end
        chk("pending clear", {7'h0, o_resp_pending}, 8'h00);
    endtask

    // a packet that must leave no reply behind
    task automatic no_reply(input logic [31:0] p);
        u_host.send_pkt(tpq_pkg::TPQ_I2C_ADDR, p, acks);
        chk("pending idle", {7'h0, o_resp_pending}, 8'h00);
        u_host.fetch_pkt(rsp, aack);
        chk("read refused", {7'h0, aack}, 8'h01);
    endtask

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        i_resetn = 1'b0;
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (10) @(negedge i_clk);
        i_resetn = 1'b1;
        u_host.tick(4);
        chk("reset state", {6'h0, o_power_state}, 8'h02);
        chk("reset rate", {4'h0, o_report_rate}, 8'h0a);
        u_host.send_pkt(7'h21, 32'h5350_0001, acks);
        chk("foreign addr", {7'h0, acks[4]}, 8'h01);
        no_reply(32'h5350_0001 & 32'h0);
        query(8'h50, 32'h5258_0a01);
        query(8'h00, {8'h52, 8'h00, 4'h0, FW_X, FW_Y, 4'h1});
        for (int r = 0; r < 10; r++) begin
            exp_rt = (ST_B[r][3:2] == 2'b10) ? RT_B[r][3:0] : 4'h0;
            u_host.send_pkt(tpq_pkg::TPQ_I2C_ADDR, {8'h54, ST_B[r], RT_B[r], 8'h01}, acks);
            chk("state", {6'h0, o_power_state}, {6'h0, ST_B[r][3:2]});
            chk("rate", {4'h0, o_report_rate}, {4'h0, exp_rt});
            query(8'h50, {8'h52, ST_B[r], 4'h0, exp_rt, 8'h01});
        end
        u_host.send_pkt(tpq_pkg::TPQ_I2C_ADDR, 32'h545c_0701, acks);
        chk("state kept", {6'h0, o_power_state}, 8'h02);
        chk("rate kept", {4'h0, o_report_rate}, 8'h0a);
        // mid-run reset from deep sleep must bring back the defaults
        u_host.send_pkt(tpq_pkg::TPQ_I2C_ADDR, 32'h5450_0001, acks);
        chk("sleep before reset", {6'h0, o_power_state}, 8'h00);
        i_resetn = 1'b0;
        u_host.tick(3);
        i_resetn = 1'b1;
        u_host.tick(4);
        chk("state after reset", {6'h0, o_power_state}, 8'h02);
        chk("rate after reset", {4'h0, o_report_rate}, 8'h0a);
        query(8'h50, 32'h5258_0a01);
        no_reply(32'h5550_0001);
        no_reply(32'h53f0_0001);
        close_out();
    end
endmodule

// file: logic/tpq_cmd_decode.sv
// decodes a complete four-byte host packet into a response or a power update
module tpq_cmd_decode #(
    parameter logic [3:0] FW_MINOR_X = 4'h0,
    parameter logic [3:0] FW_MINOR_Y = 4'h2
) (
    input  wire tpq_pkg::tpq_packet_type  i_pkt,
    input  wire tpq_pkg::tpq_pwr_cfg_type i_cfg,
    output tpq_pkg::tpq_packet_type       o_resp,
    output logic                          o_resp_valid,
    output tpq_pkg::tpq_pwr_cfg_type      o_wr_cfg,
    output logic                          o_wr_valid
);
    wire        is_read     = (i_pkt.b0 == tpq_pkg::TPQ_ID_READ);
    wire        is_write    = (i_pkt.b0 == tpq_pkg::TPQ_ID_WRITE);
    wire        sel_fw      = (i_pkt.b1 == tpq_pkg::TPQ_SEL_FW);
    wire        sel_pwr     = (i_pkt.b1 == tpq_pkg::TPQ_SEL_PWR);
    wire [1:0]  wr_state    = i_pkt.b1[tpq_pkg::TPQ_STATE_MSB:tpq_pkg::TPQ_STATE_LSB];
    wire        wr_legal    = (wr_state != 2'h3);
    wire        wr_normal   = (wr_state == tpq_pkg::TPQ_PWR_NORMAL);
    wire        cur_normal  = (i_cfg.state == tpq_pkg::TPQ_PWR_NORMAL);
    wire [3:0]  shown_rate  = cur_normal ? i_cfg.rate : tpq_pkg::TPQ_RATE_RSV;

    tpq_pkg::tpq_packet_type fw_resp;
    tpq_pkg::tpq_packet_type pwr_resp;

    assign fw_resp.b0  = tpq_pkg::TPQ_ID_RESP;
    assign fw_resp.b1  = tpq_pkg::TPQ_SEL_FW;
    assign fw_resp.b2  = {tpq_pkg::TPQ_FW_HI, FW_MINOR_X};
    assign fw_resp.b3  = {FW_MINOR_Y, tpq_pkg::TPQ_FW_LO};

    assign pwr_resp.b0 = tpq_pkg::TPQ_ID_RESP;
    assign pwr_resp.b1 = {tpq_pkg::TPQ_PWR_HI, i_cfg.state, tpq_pkg::TPQ_STATE_RSV};
    assign pwr_resp.b2 = {tpq_pkg::TPQ_RATE_HI, shown_rate};
    assign pwr_resp.b3 = tpq_pkg::TPQ_TRAILER;

    // unknown ids or selectors yield nothing
    assign o_resp_valid = is_read && (sel_fw || sel_pwr);
    assign o_resp       = sel_pwr ? pwr_resp : fw_resp;

    // any legal state may follow any other, deep sleep included
    assign o_wr_valid     = is_write && (i_pkt.b1[7:4] == tpq_pkg::TPQ_PWR_HI) && wr_legal;
    assign o_wr_cfg.state = tpq_pkg::tpq_power_type'(wr_state);
    assign o_wr_cfg.rate  = wr_normal ? i_pkt.b2[3:0] : i_cfg.rate;
endmodule

// file: logic/tpq_packet_top.sv
// i2c slave with four-byte packet handling for version and power queries
//
// What this block does
// - i2c slave at seven-bit address 0x20
// - version reply starts 52 then 00
// - power reply 52, 5s, 0r, 01
// - write 54 5s 0r 01 applies state
// - state bits: 10 normal, 01 idle, 00 sleep
// - rate nibble selects normal report rate
// - rate nibble reserved zero outside normal
// - any state reachable from any other
module tpq_packet_top #(
    parameter logic [3:0] FW_MINOR_X = 4'h0,  // arbitrary value
    parameter logic [3:0] FW_MINOR_Y = 4'h2   // arbitrary value
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_scl,
    input  wire logic                    i_sda,
    output logic                         o_sda_out,
    output logic                         o_sda_oe,
    output tpq_pkg::tpq_power_type       o_power_state,
    output logic [3:0]                   o_report_rate,
    output logic                         o_resp_pending
);
    tpq_pkg::tpq_link_state_type state;
    tpq_pkg::tpq_link_state_type next_state;
    tpq_pkg::tpq_pwr_cfg_type    cfg;
    tpq_pkg::tpq_packet_type     rx_pkt;
    tpq_pkg::tpq_packet_type     resp;
    tpq_pkg::tpq_packet_type     dec_resp;
    tpq_pkg::tpq_pwr_cfg_type    dec_cfg;
    logic                        dec_resp_valid;
    logic                        dec_wr_valid;

    logic                        scl_q;
    logic                        sda_q;
    logic [7:0]                  shift;
    logic [2:0]                  bit_cnt;
    logic                        byte_done;
    logic                        read_dir;
    logic [1:0]                  rx_idx;
    logic [1:0]                  tx_idx;
    logic                        pending;
    logic                        sda_drive;

    // bus conditions from live pin levels against their registered copies
    wire scl_rise   = i_scl && !scl_q;
    wire scl_fall   = !i_scl && scl_q;
    wire start_cond = i_scl && scl_q && sda_q && !i_sda;
    wire stop_cond  = i_scl && scl_q && !sda_q && i_sda;

    // address phase: match and direction, reads only acked with a reply waiting
    wire addr_match = (shift[7:1] == tpq_pkg::TPQ_I2C_ADDR);
    wire addr_ack   = addr_match && (!shift[0] || pending);

    // byte presented for each read slot
    function automatic logic [7:0] resp_byte(input tpq_pkg::tpq_packet_type p, input logic [1:0] idx);
        logic [7:0] b;
        b = p.b0;
        unique case (idx)
            2'h0: b = p.b0;
            2'h1: b = p.b1;
            2'h2: b = p.b2;
            2'h3: b = p.b3;
        endcase
        return b;
    endfunction

    wire [7:0] tx_byte  = pending ? resp_byte(resp, tx_idx) : tpq_pkg::TPQ_FILL_BYTE;
    wire       rx_last  = (rx_idx == tpq_pkg::TPQ_BYTE_LAST);
    wire       rx_store = (state == tpq_pkg::TPQ_LINK_RX) && scl_fall && byte_done;
    wire       pkt_done = rx_store && rx_last;
    wire       tx_take  = scl_fall && ((state == tpq_pkg::TPQ_LINK_ADDR_AK && read_dir)
                                    || (state == tpq_pkg::TPQ_LINK_TX_AK));
    wire       tx_end   = tx_take && pending && (tx_idx == tpq_pkg::TPQ_BYTE_LAST);

    tpq_pkg::tpq_packet_type full_pkt;
    assign full_pkt = {rx_pkt.b0, rx_pkt.b1, rx_pkt.b2, shift};

    tpq_cmd_decode #(
        .FW_MINOR_X (FW_MINOR_X),
        .FW_MINOR_Y (FW_MINOR_Y)
    ) u_decode (
        .i_pkt        (full_pkt),
        .i_cfg        (cfg),
        .o_resp       (dec_resp),
        .o_resp_valid (dec_resp_valid),
        .o_wr_cfg     (dec_cfg),
        .o_wr_valid   (dec_wr_valid)
    );

    // link state machine
    always_comb begin
        next_state = state;
        if (start_cond) begin
            next_state = tpq_pkg::TPQ_LINK_ADDR;
        end else if (stop_cond) begin
            next_state = tpq_pkg::TPQ_LINK_IDLE;
        end else if (scl_fall) begin
            unique case (state)
                tpq_pkg::TPQ_LINK_IDLE: begin
                    next_state = tpq_pkg::TPQ_LINK_IDLE;
                end
                tpq_pkg::TPQ_LINK_ADDR: begin
                    if (byte_done) begin
                        next_state = addr_ack ? tpq_pkg::TPQ_LINK_ADDR_AK : tpq_pkg::TPQ_LINK_IDLE;
                    end
                end
                tpq_pkg::TPQ_LINK_ADDR_AK: begin
                    next_state = read_dir ? tpq_pkg::TPQ_LINK_TX : tpq_pkg::TPQ_LINK_RX;
                end
                tpq_pkg::TPQ_LINK_RX: begin
                    if (byte_done) begin
                        next_state = tpq_pkg::TPQ_LINK_RX_AK;
                    end
                end
                tpq_pkg::TPQ_LINK_RX_AK: begin
                    next_state = tpq_pkg::TPQ_LINK_RX;
                end
                tpq_pkg::TPQ_LINK_TX: begin
                    if (bit_cnt == tpq_pkg::TPQ_BIT_LAST) begin
                        next_state = tpq_pkg::TPQ_LINK_TX_AK;
                    end
                end
                tpq_pkg::TPQ_LINK_TX_AK: begin
                    next_state = tpq_pkg::TPQ_LINK_TX;
                end
                default: begin
                    next_state = tpq_pkg::TPQ_LINK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= tpq_pkg::TPQ_LINK_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            // master nack at the ninth clock ends the read
            if (state == tpq_pkg::TPQ_LINK_TX_AK && scl_rise && i_sda) begin
                state <= tpq_pkg::TPQ_LINK_IDLE;
            end else begin
                state <= next_state;
            end
        end
    end

    // bit shifting: sample on rising scl, shift out on falling scl
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift     <= tpq_pkg::TPQ_FILL_BYTE;
            bit_cnt   <= tpq_pkg::TPQ_BIT_FIRST;
            byte_done <= 1'b0;
        end else if (start_cond) begin
            bit_cnt   <= tpq_pkg::TPQ_BIT_FIRST;
            byte_done <= 1'b0;
        end else if (scl_rise && (state == tpq_pkg::TPQ_LINK_ADDR || state == tpq_pkg::TPQ_LINK_RX)) begin
            shift     <= {shift[6:0], i_sda};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == tpq_pkg::TPQ_BIT_LAST);
        end else if (tx_take) begin
            shift     <= tx_byte;
            bit_cnt   <= tpq_pkg::TPQ_BIT_FIRST;
            byte_done <= 1'b0;
        end else if (scl_fall && state == tpq_pkg::TPQ_LINK_TX) begin
            shift     <= {shift[6:0], 1'b1};
            bit_cnt   <= bit_cnt + 3'h1;
        end else if (scl_fall && byte_done) begin
            byte_done <= 1'b0;
        end
    end

    // open-drain data line: pulls low for acks and zero bits
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sda_drive <= 1'b0;
            read_dir  <= 1'b0;
        end else if (start_cond || stop_cond) begin
            sda_drive <= 1'b0;
        end else if (scl_fall) begin
            if (state == tpq_pkg::TPQ_LINK_ADDR && byte_done) begin
                sda_drive <= addr_ack;
                read_dir  <= shift[0];
            end else if (rx_store) begin
                sda_drive <= 1'b1;
            end else if (tx_take) begin
                sda_drive <= !tx_byte[7];
            end else if (state == tpq_pkg::TPQ_LINK_TX && bit_cnt != tpq_pkg::TPQ_BIT_LAST) begin
                sda_drive <= !shift[6];
            end else begin
                sda_drive <= 1'b0;
            end
        end
    end

    // packet assembly, restarted by every start condition
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_pkt <= '0;
            rx_idx <= tpq_pkg::TPQ_BYTE_FIRST;
        end else if (start_cond) begin
            rx_idx <= tpq_pkg::TPQ_BYTE_FIRST;
        end else if (rx_store) begin
            rx_idx <= rx_idx + 2'h1;
            unique case (rx_idx)
                2'h0: rx_pkt.b0 <= shift;
                2'h1: rx_pkt.b1 <= shift;
                2'h2: rx_pkt.b2 <= shift;
                2'h3: rx_pkt.b3 <= shift;
            endcase
        end
    end

    // response holding; loading the fourth reply byte for sending or any new packet retires it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            resp    <= '0;
            pending <= 1'b0;
            tx_idx  <= tpq_pkg::TPQ_BYTE_FIRST;
        end else if (pkt_done) begin
            resp    <= dec_resp;
            pending <= dec_resp_valid;
            tx_idx  <= tpq_pkg::TPQ_BYTE_FIRST;
        end else if (tx_end) begin
            pending <= 1'b0;
            tx_idx  <= tpq_pkg::TPQ_BYTE_FIRST;
        end else if (tx_take && pending) begin
            tx_idx  <= tx_idx + 2'h1;
        end
    end

    // power state and report rate
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg.state <= tpq_pkg::TPQ_PWR_RESET;
            cfg.rate  <= tpq_pkg::TPQ_RATE_RESET;
        end else if (pkt_done && dec_wr_valid) begin
            cfg <= dec_cfg;
        end
    end

    // registered outputs
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sda_out      <= 1'b0;
            o_sda_oe       <= 1'b0;
            o_power_state  <= tpq_pkg::TPQ_PWR_RESET;
            o_report_rate  <= tpq_pkg::TPQ_RATE_RESET;
            o_resp_pending <= 1'b0;
        end else begin
            o_sda_out      <= 1'b0;
            o_sda_oe       <= sda_drive;
            o_power_state  <= cfg.state;
            o_report_rate  <= (cfg.state == tpq_pkg::TPQ_PWR_NORMAL) ? cfg.rate : tpq_pkg::TPQ_RATE_RSV;
            o_resp_pending <= pending;
        end
    end
endmodule

// file: shared/tpq_pkg.sv
// shared constants and types for the touchpad query and power packet handler
package tpq_pkg;

    // link addressing and byte framing
    localparam logic [6:0] TPQ_I2C_ADDR     = 7'h20;
    localparam int         TPQ_BYTE_BITS    = 8;
    localparam logic [2:0] TPQ_BIT_LAST     = 3'h7;
    localparam logic [2:0] TPQ_BIT_FIRST    = 3'h0;
    localparam logic [1:0] TPQ_BYTE_FIRST   = 2'h0;
    localparam logic [1:0] TPQ_BYTE_LAST    = 2'h3;
    localparam logic [7:0] TPQ_FILL_BYTE    = 8'hff;

    // packet identifiers and selectors
    localparam logic [7:0] TPQ_ID_READ      = 8'h53;
    localparam logic [7:0] TPQ_ID_WRITE     = 8'h54;
    localparam logic [7:0] TPQ_ID_RESP      = 8'h52;
    localparam logic [7:0] TPQ_SEL_FW       = 8'h00;
    localparam logic [7:0] TPQ_SEL_PWR      = 8'h50;
    localparam logic [7:0] TPQ_TRAILER      = 8'h01;

    // nibble layout of the payload bytes
    localparam logic [3:0] TPQ_PWR_HI       = 4'h5;
    localparam logic [3:0] TPQ_RATE_HI      = 4'h0;
    localparam logic [3:0] TPQ_FW_HI        = 4'h0;
    localparam logic [3:0] TPQ_FW_LO        = 4'h1;
    localparam logic [3:0] TPQ_RATE_RSV     = 4'h0;
    localparam logic [1:0] TPQ_STATE_RSV    = 2'h0;
    localparam int         TPQ_STATE_MSB    = 3;
    localparam int         TPQ_STATE_LSB    = 2;

    // report rate codes in normal mode
    localparam logic [3:0] TPQ_RATE_80HZ    = 4'hf;
    localparam logic [3:0] TPQ_RATE_100HZ   = 4'ha;
    localparam logic [3:0] TPQ_RATE_115HZ   = 4'h7;
    localparam logic [3:0] TPQ_RATE_130HZ   = 4'h5;
    localparam logic [3:0] TPQ_RATE_150HZ   = 4'h3;

    typedef enum logic [1:0] {
        TPQ_PWR_DEEP   = 2'b00,
        TPQ_PWR_IDLE   = 2'b01,
        TPQ_PWR_NORMAL = 2'b10
    } tpq_power_type;

    typedef struct packed {
        tpq_power_type state;
        logic [3:0]    rate;
    } tpq_pwr_cfg_type;

    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } tpq_packet_type;

    typedef enum logic [2:0] {
        TPQ_LINK_IDLE    = 3'b000,
        TPQ_LINK_ADDR    = 3'b001,
        TPQ_LINK_ADDR_AK = 3'b010,
        TPQ_LINK_RX      = 3'b011,
        TPQ_LINK_RX_AK   = 3'b100,
        TPQ_LINK_TX      = 3'b101,
        TPQ_LINK_TX_AK   = 3'b110
    } tpq_link_state_type;

    localparam tpq_power_type TPQ_PWR_RESET  = TPQ_PWR_NORMAL;
    localparam logic [3:0]    TPQ_RATE_RESET = TPQ_RATE_100HZ;

endpackage
